// ===== src/lcsm_consts.svh
// Offsets, field positions, reset values and timing counts of the load switch block
// How it works
// - The 4-bit load chain field sets both the short-to-ground threshold and the jump ratio; codes 1-15 mean that many steps, 0 means 16, reset is 8.
// - A host write of one to the load switch start bit launches the multi-load switching routine; the bit resets to zero.
// - The read-only load switch done bit is one only after a successful routine and clears when the start bit is set.
// - The half peak limit bit halves the switch peak overcurrent threshold during multi-load operation; otherwise it stays at full.
// - The amplifier current reduce bit cuts the error amplifier current to a fifth, only while the routine runs.
// - The 8-bit delay code, reset 0x20, sets the routine delay in switching periods, zero shortest and all ones longest.
// - The LED current status reads 00 target to +25%, 01 above +25%, 10 target to -25%, 11 below -25%.
// - The input current status reads 00 for 75-90% of limit, 01 for 90% to limit, 10 for 60-75%, 11 below 60%.
// - A host write of one to the monitor start bit begins the current monitoring routine; the bit resets to zero.
// - The read-only monitor done bit signals the end of monitoring and reads zero until it has completed.
// - The regulation mode readback reads 01 for buck (reset), 10 for boost and 11 for buck-boost.
// - Writes to unimplemented addresses are ignored; reads above the last address return the diagnosis frame, reads below the first return nothing.
`ifndef LCSM_CONSTS_SVH
`define LCSM_CONSTS_SVH

// Register addresses
`define LCSM_ADDR_SETUP 4'h4
`define LCSM_ADDR_DELAY 4'h5
`define LCSM_ADDR_MON 4'h6
`define LCSM_ADDR_REGU 4'h7
`define LCSM_ADDR_LAST 4'h7
`define LCSM_ADDR_FIRST 4'h4

// Field positions
`define LCSM_BIT_DONE 4
`define LCSM_BIT_START 5
`define LCSM_BIT_HALF 6
`define LCSM_BIT_AMP 7

// Reset values
`define LCSM_RST_CHAIN 4'h8
`define LCSM_RST_DELAY 8'h20
`define LCSM_RST_REGU 2'h1

// Status codes
`define LCSM_LED_OK_HI 2'h0
`define LCSM_LED_HIGH 2'h1
`define LCSM_LED_OK_LO 2'h2
`define LCSM_LED_LOW 2'h3
`define LCSM_IN_75_90 2'h0
`define LCSM_IN_90_LIM 2'h1
`define LCSM_IN_60_75 2'h2
`define LCSM_IN_BELOW 2'h3
`define LCSM_MODE_BUCK 2'h1
`define LCSM_MODE_BOOST 2'h2
`define LCSM_MODE_BB 2'h3

// Monitoring window in switching periods
`define LCSM_MON_TICKS 8'h10

`endif

// ===== src/lcsm_pkg.sv
// Types shared by the load switch and current monitor logic
package lcsm_pkg;
	typedef enum logic {LCSM_IDLE, LCSM_RUN} lcsm_state_type;
endpackage

// ===== src/lcsm_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module lcsm_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule

// ===== src/lcsm_routine.sv
// Routine sequencer: waits a number of switching ticks, reports done or fail
`timescale 1ns/100ps
module lcsm_routine #(
	parameter int CW = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic tick,
	input wire logic [CW-1:0] len,
	input wire logic abort,
	output logic busy,
	output logic done,
	output logic fail
);
	lcsm_pkg::lcsm_state_type state_q;
	lcsm_pkg::lcsm_state_type state_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic done_q;
	logic done_d;
	logic fail_q;
	logic fail_d;

	// A start while running restarts the wait from the new length
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		fail_d = 1'b0;
		case (state_q)
			lcsm_pkg::LCSM_IDLE: begin
				if (start) begin
					state_d = lcsm_pkg::LCSM_RUN;
					cnt_d = len;
				end
			end
			lcsm_pkg::LCSM_RUN: begin
				if (start) begin
					cnt_d = len;
				end else if (abort) begin
					state_d = lcsm_pkg::LCSM_IDLE;
					fail_d = 1'b1;
				end else if (tick) begin
					if (cnt_q == '0) begin
						state_d = lcsm_pkg::LCSM_IDLE;
						done_d = 1'b1;
					end else begin
						cnt_d = cnt_q - 1'b1;
					end
				end
			end
			default: begin
				state_d = lcsm_pkg::LCSM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= lcsm_pkg::LCSM_IDLE;
			cnt_q <= '0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			fail_q <= fail_d;
		end
	end

	assign busy = (state_q == lcsm_pkg::LCSM_RUN);
	assign done = done_q;
	assign fail = fail_q;
endmodule

// ===== src/lcsm_regs.sv
// Load switch setup, current monitor and regulation readback registers
`timescale 1ns/100ps
`include "lcsm_consts.svh"
module lcsm_regs (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic REG_RDVALID,
	output logic REG_DIAG,
	input wire logic SW_CLK_PIN,
	input wire logic LOAD_FAULT_PIN,
	input wire logic LED_ABOVE_TARGET,
	input wire logic LED_ABOVE_P25,
	input wire logic LED_BELOW_M25,
	input wire logic IN_ABOVE_60,
	input wire logic IN_ABOVE_75,
	input wire logic IN_ABOVE_90,
	input wire logic BUCK_ACTIVE,
	input wire logic BOOST_ACTIVE,
	output logic [4:0] LOAD_CHAIN_STEPS,
	output logic [7:0] LOAD_SWITCH_DELAY_CODE,
	output logic MULTI_LOAD_SWITCHING,
	output logic HALF_PEAK_LIMIT,
	output logic AMP_CURRENT_REDUCE,
	output logic MONITOR_RUN
);
	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	logic [9:0] pin_sync;
	logic sw_clk_s;
	logic fault_s;
	logic led_tgt_s;
	logic led_p25_s;
	logic led_m25_s;
	logic in60_s;
	logic in75_s;
	logic in90_s;
	logic buck_s;
	logic boost_s;

	lcsm_sync #(
		.WIDTH(10)
	) u_sync (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.din({SW_CLK_PIN, LOAD_FAULT_PIN, LED_ABOVE_TARGET, LED_ABOVE_P25,
			LED_BELOW_M25, IN_ABOVE_60, IN_ABOVE_75, IN_ABOVE_90,
			BUCK_ACTIVE, BOOST_ACTIVE}),
		.dout(pin_sync)
	);

	assign {sw_clk_s, fault_s, led_tgt_s, led_p25_s, led_m25_s,
		in60_s, in75_s, in90_s, buck_s, boost_s} = pin_sync;

	// ****************************************************************
	// Switching period enable
	// ****************************************************************
	logic sw_prev_q;
	logic sw_prev_d;
	logic sw_tick;

	// Rising edge of the synchronised switching clock, one cycle wide
	always_comb begin
		sw_prev_d = sw_clk_s;
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sw_prev_q <= 1'b0;
		end else begin
			sw_prev_q <= sw_prev_d;
		end
	end

	assign sw_tick = sw_clk_s & ~sw_prev_q;

	// ****************************************************************
	// Register decode
	// ****************************************************************
	logic wr_setup;
	logic wr_delay;
	logic wr_mon;
	logic addr_ok;

	assign addr_ok = (REG_ADDR <= `LCSM_ADDR_LAST);
	// Writes elsewhere decode to nothing and are dropped
	assign wr_setup = REG_WR & (REG_ADDR == `LCSM_ADDR_SETUP);
	assign wr_delay = REG_WR & (REG_ADDR == `LCSM_ADDR_DELAY);
	assign wr_mon = REG_WR & (REG_ADDR == `LCSM_ADDR_MON);

	// ****************************************************************
	// Control and status registers
	// ****************************************************************
	logic [3:0] chain_q;
	logic [3:0] chain_d;
	logic ls_start_q;
	logic ls_start_d;
	logic ls_done_q;
	logic ls_done_d;
	logic half_q;
	logic half_d;
	logic amp_q;
	logic amp_d;
	logic [7:0] delay_q;
	logic [7:0] delay_d;
	logic mon_start_q;
	logic mon_start_d;
	logic mon_done_q;
	logic mon_done_d;
	logic [1:0] led_stat_q;
	logic [1:0] led_stat_d;
	logic [1:0] in_stat_q;
	logic [1:0] in_stat_d;
	logic [1:0] mode_q;
	logic [1:0] mode_d;
	logic ls_busy;
	logic ls_ok;
	logic mon_busy;
	logic mon_ok;
	logic [1:0] led_code;
	logic [1:0] in_code;

	// Comparator ladders to the coded status fields
	always_comb begin
		if (led_p25_s) begin
			led_code = `LCSM_LED_HIGH;
		end else if (led_tgt_s) begin
			led_code = `LCSM_LED_OK_HI;
		end else if (led_m25_s) begin
			led_code = `LCSM_LED_LOW;
		end else begin
			led_code = `LCSM_LED_OK_LO;
		end
		if (in90_s) begin
			in_code = `LCSM_IN_90_LIM;
		end else if (in75_s) begin
			in_code = `LCSM_IN_75_90;
		end else if (in60_s) begin
			in_code = `LCSM_IN_60_75;
		end else begin
			in_code = `LCSM_IN_BELOW;
		end
	end

	always_comb begin
		chain_d = chain_q;
		half_d = half_q;
		amp_d = amp_q;
		delay_d = delay_q;
		ls_start_d = ls_start_q;
		mon_start_d = mon_start_q;
		ls_done_d = ls_done_q;
		mon_done_d = mon_done_q;
		led_stat_d = led_stat_q;
		in_stat_d = in_stat_q;
		mode_d = mode_q;
		// Start bits last one cycle: the sequencer takes them on that edge
		if (ls_start_q) begin
			ls_start_d = 1'b0;
		end
		if (mon_start_q) begin
			mon_start_d = 1'b0;
		end
		if (wr_setup) begin
			chain_d = REG_WDATA[3:0];
			half_d = REG_WDATA[`LCSM_BIT_HALF];
			amp_d = REG_WDATA[`LCSM_BIT_AMP];
			if (REG_WDATA[`LCSM_BIT_START]) begin
				ls_start_d = 1'b1;
				ls_done_d = 1'b0;
			end
		end
		if (wr_delay) begin
			delay_d = REG_WDATA;
		end
		// Only the start bit of the monitor register is writable
		if (wr_mon && REG_WDATA[`LCSM_BIT_START]) begin
			mon_start_d = 1'b1;
			mon_done_d = 1'b0;
		end
		// Completion is set after any clear so that it wins
		if (ls_ok) begin
			ls_done_d = 1'b1;
		end
		if (mon_ok) begin
			mon_done_d = 1'b1;
			led_stat_d = led_code;
			in_stat_d = in_code;
		end
		// No mode pin active keeps the buck reading
		case ({boost_s, buck_s})
			2'h2: mode_d = `LCSM_MODE_BOOST;
			2'h3: mode_d = `LCSM_MODE_BB;
			default: mode_d = `LCSM_MODE_BUCK;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			chain_q <= `LCSM_RST_CHAIN;
			half_q <= 1'b0;
			amp_q <= 1'b0;
			delay_q <= `LCSM_RST_DELAY;
			ls_start_q <= 1'b0;
			mon_start_q <= 1'b0;
			ls_done_q <= 1'b0;
			mon_done_q <= 1'b0;
			led_stat_q <= `LCSM_LED_OK_HI;
			in_stat_q <= `LCSM_IN_75_90;
			mode_q <= `LCSM_RST_REGU;
		end else begin
			chain_q <= chain_d;
			half_q <= half_d;
			amp_q <= amp_d;
			delay_q <= delay_d;
			ls_start_q <= ls_start_d;
			mon_start_q <= mon_start_d;
			ls_done_q <= ls_done_d;
			mon_done_q <= mon_done_d;
			led_stat_q <= led_stat_d;
			in_stat_q <= in_stat_d;
			mode_q <= mode_d;
		end
	end

	// ****************************************************************
	// Routine sequencers
	// ****************************************************************
	// A fault while switching the loads aborts, leaving done at zero
	lcsm_routine #(
		.CW(8)
	) u_load_switch (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.start(ls_start_q),
		.tick(sw_tick),
		.len(delay_q),
		.abort(fault_s),
		.busy(ls_busy),
		.done(ls_ok),
		.fail()
	);

	lcsm_routine #(
		.CW(8)
	) u_monitor (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.start(mon_start_q),
		.tick(sw_tick),
		.len(`LCSM_MON_TICKS),
		.abort(1'b0),
		.busy(mon_busy),
		.done(mon_ok),
		.fail()
	);

	// ****************************************************************
	// Outputs to the power stage
	// ****************************************************************
	logic [4:0] steps_q;
	logic [4:0] steps_d;
	logic [7:0] dly_out_q;
	logic [7:0] dly_out_d;
	logic run_q;
	logic run_d;
	logic half_out_q;
	logic half_out_d;
	logic amp_out_q;
	logic amp_out_d;
	logic mon_run_q;
	logic mon_run_d;

	always_comb begin
		// Code zero is the largest setting
		if (chain_q == 4'h0) begin
			steps_d = 5'h10;
		end else begin
			steps_d = {1'b0, chain_q};
		end
		dly_out_d = delay_q;
		run_d = ls_busy;
		half_out_d = half_q & ls_busy;
		amp_out_d = amp_q & ls_busy;
		mon_run_d = mon_busy;
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			steps_q <= 5'h08;
			dly_out_q <= `LCSM_RST_DELAY;
			run_q <= 1'b0;
			half_out_q <= 1'b0;
			amp_out_q <= 1'b0;
			mon_run_q <= 1'b0;
		end else begin
			steps_q <= steps_d;
			dly_out_q <= dly_out_d;
			run_q <= run_d;
			half_out_q <= half_out_d;
			amp_out_q <= amp_out_d;
			mon_run_q <= mon_run_d;
		end
	end

	assign LOAD_CHAIN_STEPS = steps_q;
	assign LOAD_SWITCH_DELAY_CODE = dly_out_q;
	assign MULTI_LOAD_SWITCHING = run_q;
	assign HALF_PEAK_LIMIT = half_out_q;
	assign AMP_CURRENT_REDUCE = amp_out_q;
	assign MONITOR_RUN = mon_run_q;

	// ****************************************************************
	// Read path
	// ****************************************************************
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic rdvalid_q;
	logic rdvalid_d;
	logic diag_q;
	logic diag_d;

	always_comb begin
		rdata_d = 8'h00;
		rdvalid_d = 1'b0;
		diag_d = 1'b0;
		if (REG_RD) begin
			case (REG_ADDR)
				`LCSM_ADDR_SETUP: begin
					rdata_d = {amp_q, half_q, ls_start_q, ls_done_q, chain_q};
					rdvalid_d = 1'b1;
				end
				`LCSM_ADDR_DELAY: begin
					rdata_d = delay_q;
					rdvalid_d = 1'b1;
				end
				`LCSM_ADDR_MON: begin
					rdata_d = {2'h0, mon_start_q, mon_done_q, in_stat_q,
						led_stat_q};
					rdvalid_d = 1'b1;
				end
				`LCSM_ADDR_REGU: begin
					rdata_d = {4'h0, mode_q, 2'h0};
					rdvalid_d = 1'b1;
				end
				default: begin
					// Lower addresses belong to another register block
					diag_d = ~addr_ok;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_q <= 8'h00;
			rdvalid_q <= 1'b0;
			diag_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rdvalid_q <= rdvalid_d;
			diag_q <= diag_d;
		end
	end

	assign REG_RDATA = rdata_q;
	assign REG_RDVALID = rdvalid_q;
	assign REG_DIAG = diag_q;
endmodule

// ===== test/lcsm_regs_checker.sv
// Port assertions for the load switch and current monitor registers
`timescale 1ns/100ps
module lcsm_chk (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RDVALID,
	input wire logic REG_DIAG,
	input wire logic [4:0] LOAD_CHAIN_STEPS,
	input wire logic [7:0] LOAD_SWITCH_DELAY_CODE,
	input wire logic MULTI_LOAD_SWITCHING,
	input wire logic HALF_PEAK_LIMIT,
	input wire logic AMP_CURRENT_REDUCE
);
	// ****
	// Expected step count
	// ****
	logic [4:0] ch_q;
	logic [4:0] ch_d;
	logic wr_dly;
	assign wr_dly = REG_WR && REG_ADDR == 4'h5;
	// Code zero maps to sixteen through the carry bit
	always_comb begin
		ch_d = ch_q;
		if (REG_WR && REG_ADDR == 4'h4) begin
			ch_d = {REG_WDATA[3:0] == 4'h0, REG_WDATA[3:0]};
		end
	end
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ch_q <= 5'h08;
		end else begin
			ch_q <= ch_d;
		end
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	rd_answer_a: assert property (
		REG_RD && REG_ADDR[3:2] == 2'h1 |=> REG_RDVALID && !REG_DIAG)
		else $error("mapped read unanswered");
	diag_answer_a: assert property (
		REG_RD && REG_ADDR[3] |=> REG_DIAG && !REG_RDVALID && REG_RDATA == 8'h00)
		else $error("unmapped read wrong");
	low_silent_a: assert property (
		REG_RD && REG_ADDR[3:2] == 2'h0 |=> !REG_RDVALID && !REG_DIAG)
		else $error("foreign read answered");
	write_silent_a: assert property (
		REG_WR |=> !REG_RDVALID && !REG_DIAG)
		else $error("write answered");
	chain_map_a: assert property (
		REG_WR && REG_ADDR == 4'h4 |=> ##[0:1] LOAD_CHAIN_STEPS == ch_q)
		else $error("step count wrong");
	delay_hold_a: assert property (
		$changed(LOAD_SWITCH_DELAY_CODE) |-> $past(wr_dly) || $past(wr_dly, 2))
		else $error("delay code changed alone");
	half_gate_a: assert property (
		HALF_PEAK_LIMIT |-> MULTI_LOAD_SWITCHING || $past(MULTI_LOAD_SWITCHING))
		else $error("half limit outside routine");
	amp_gate_a: assert property (
		AMP_CURRENT_REDUCE |-> MULTI_LOAD_SWITCHING || $past(MULTI_LOAD_SWITCHING))
		else $error("amp cut outside routine");
	cover property (REG_DIAG);
	cover property ($fell(MULTI_LOAD_SWITCHING));
	cover property (HALF_PEAK_LIMIT && AMP_CURRENT_REDUCE);
endmodule
bind lcsm_regs lcsm_chk chk_u (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.REG_RDVALID(REG_RDVALID), .REG_DIAG(REG_DIAG),
	.LOAD_CHAIN_STEPS(LOAD_CHAIN_STEPS),
	.LOAD_SWITCH_DELAY_CODE(LOAD_SWITCH_DELAY_CODE),
	.MULTI_LOAD_SWITCHING(MULTI_LOAD_SWITCHING),
	.HALF_PEAK_LIMIT(HALF_PEAK_LIMIT),
	.AMP_CURRENT_REDUCE(AMP_CURRENT_REDUCE));

// ===== test/lcsm_host.sv
// Register host model issuing single byte reads and writes
`timescale 1ns/100ps
module lcsm_host (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rdvalid,
	input wire logic reg_diag
);
	// ****
	// Bus cycles
	// ****
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
	end
	// Released lines are inverted so stale values never look valid
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] w);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~w;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] q,
		output logic v, output logic g);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		q = reg_rdata;
		v = reg_rdvalid;
		g = reg_diag;
	endtask
endmodule

// ===== test/test_lcsm_regs.sv
// Self-checking bench for the load switch and current monitor registers
`timescale 1ns/100ps
`define CHK(x, e) begin checks++; if ((x) !== (e)) begin n_errors++; \
$display("MISMATCH t=%0t got %0h exp %0h", $time, x, e); end end
module test_lcsm_regs;
	// ****
	// Signals and model state
	// ****
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic sw_en = 1'b0;
	logic sw_clk = 1'b0;
	logic fault = 1'b0;
	logic [7:0] cmp = 8'h00;
	logic wr, rd, rdv, diag, mls, half, amp, mon, v, g;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, dly, d;
	logic [4:0] steps;
	logic [7:0] m [4:7];
	logic [5:0] cq [$] = '{6'h3B, 6'h19, 6'h0C, 6'h00};
	int n_errors = 0;
	int checks = 0;
	int seed = 32'hA8A5;
	int i, n, nr;
	initial forever #20 core_clk = ~core_clk;
	// Switching pin stands still between routines
	always begin
		repeat (4) @(posedge core_clk);
		if (sw_en) sw_clk <= ~sw_clk;
	end
	always @(posedge sw_clk) nr++;
	lcsm_host host_u (.clk(core_clk), .reg_wr(wr), .reg_rd(rd),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
		.reg_rdvalid(rdv), .reg_diag(diag));
	lcsm_regs dut_u (.CORE_CLK(core_clk), .RSTN(rstn), .REG_WR(wr),
		.REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.REG_RDVALID(rdv), .REG_DIAG(diag), .SW_CLK_PIN(sw_clk),
		.LOAD_FAULT_PIN(fault), .LED_ABOVE_TARGET(cmp[0]),
		.LED_ABOVE_P25(cmp[1]), .LED_BELOW_M25(cmp[2]),
		.IN_ABOVE_60(cmp[3]), .IN_ABOVE_75(cmp[4]), .IN_ABOVE_90(cmp[5]),
		.BUCK_ACTIVE(cmp[6]), .BOOST_ACTIVE(cmp[7]),
		.LOAD_CHAIN_STEPS(steps), .LOAD_SWITCH_DELAY_CODE(dly),
		.MULTI_LOAD_SWITCHING(mls), .HALF_PEAK_LIMIT(half),
		.AMP_CURRENT_REDUCE(amp), .MONITOR_RUN(mon));
	function automatic logic [3:0] mon_code(input logic [5:0] c);
		logic [1:0] l;
		logic [1:0] s;
		l = c[1] ? 2'h1 : c[0] ? 2'h0 : c[2] ? 2'h3 : 2'h2;
		s = c[5] ? 2'h1 : c[4] ? 2'h0 : c[3] ? 2'h2 : 2'h3;
		return {s, l};
	endfunction
	task automatic conclude;
		$display("Errors %0d in %0d checks", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
		host_u.rd_reg(a, d, v, g);
		`CHK(v, 1'b1)
		`CHK(d, e)
	endtask
	task automatic launch(input logic [3:0] a, input logic [7:0] w);
		nr = 0;
		host_u.wr_reg(a, w);
		sw_en <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic wait_end;
		n = 0;
		while ((mls || mon) && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		sw_en <= 1'b0;
		if (mls || mon) begin
			n_errors++;
			$display("MISMATCH t=%0t routine hangs", $time);
			conclude();
		end
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		`CHK({steps, dly}, {5'h08, 8'h20})
		m[4] = 8'h08;
		m[5] = 8'h20;
		m[6] = 8'h00;
		m[7] = 8'h04;
		for (i = 4; i < 8; i++) rdchk(4'(i), m[i]);
		for (i = 0; i < 16; i++) begin
			m[4] = 8'($random(seed)) & 8'hC0 | 8'(i);
			host_u.wr_reg(4'h4, m[4]);
			rdchk(4'h4, m[4]);
			`CHK(steps, i == 0 ? 5'h10 : 5'(i))
		end
		repeat (4) begin
			m[5] = 8'($random(seed));
			host_u.wr_reg(4'h5, m[5]);
			rdchk(4'h5, m[5]);
			`CHK(dly, m[5])
		end
		for (i = 7; i < 16; i++) host_u.wr_reg(4'(i), 8'hFF);
		host_u.wr_reg(4'h6, 8'hDF);
		for (i = 4; i < 8; i++) rdchk(4'(i), m[i]);
		for (i = 0; i < 16; i++) begin
			if (i < 4 || i > 7) begin
				host_u.rd_reg(4'(i), d, v, g);
				`CHK({v, g, d}, {1'b0, i > 7, 8'h00})
			end
		end
		for (i = 0; i < 4; i++) begin
			@(posedge core_clk);
			cmp[7:6] <= 2'(i);
			repeat (4) @(posedge core_clk);
			m[7] = {4'h0, i == 3 ? 2'h3 : i == 2 ? 2'h2 : 2'h1, 2'h0};
			rdchk(4'h7, m[7]);
		end
		host_u.wr_reg(4'h5, 8'h02);
		launch(4'h4, 8'hE3);
		`CHK({mls, half, amp}, 3'h7)
		rdchk(4'h4, 8'hC3);
		wait_end();
		@(posedge core_clk);
		`CHK({mls, half, amp, 8'(nr)}, {3'h0, 8'h03})
		rdchk(4'h4, 8'hD3);
		launch(4'h4, 8'h2A);
		`CHK({mls, half, amp}, 3'h4)
		rdchk(4'h4, 8'h0A);
		fault <= 1'b1;
		wait_end();
		rdchk(4'h4, 8'h0A);
		fault <= 1'b0;
		host_u.wr_reg(4'h5, 8'h00);
		launch(4'h4, 8'h21);
		wait_end();
		`CHK(nr, 1)
		rdchk(4'h4, 8'h11);
		foreach (cq[j]) begin
			@(posedge core_clk);
			cmp[5:0] <= cq[j];
			repeat (3) @(posedge core_clk);
			launch(4'h6, 8'h20);
			`CHK(mon, 1'b1)
			wait_end();
			`CHK(nr, 17)
			cmp[5:0] <= ~cq[j];
			repeat (4) @(posedge core_clk);
			rdchk(4'h6, {4'h1, mon_code(cq[j])});
		end
		// Reset in the middle of a long routine must drop the routine outputs and restore the step count and delay code
		host_u.wr_reg(4'h5, 8'h40);
		launch(4'h4, 8'hE5);
		`CHK({mls, half, amp, dly}, {3'h7, 8'h40})
		rstn <= 1'b0;
		sw_en <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		`CHK({mls, half, amp, steps, dly}, {3'h0, 5'h08, 8'h20})
		rdchk(4'h4, 8'h08);
		rdchk(4'h6, 8'h00);
		conclude();
	end
endmodule
